// File: hdl/vrc_ctrl.sv
// Controller that drives the random port of a multiport video DRAM.
// Assumes a single AHB-Lite master; DRAM data pins are resolved outside.
`timescale 1ns/1ps
module vrc_ctrl import vrc_pkg::*; #(
  parameter int PAGE_MARGIN = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic transfer_output_enable_n,
  output logic special_function_flag,
  output logic [8:0] dram_addr,
  output logic [15:0] dram_data_out,
  output logic dram_data_oe_n,
  input wire logic [15:0] dram_data_in
);
  // Longest access is under 10 cycles; margin must cover it and fit the limit
  if (PAGE_MARGIN < 10 || PAGE_MARGIN >= VRC_PAGE_LIMIT_CYC) begin : g_bad_margin
    $error("PAGE_MARGIN out of range");
  end
  typedef enum logic [10:0] {
    S_IDLE = 11'h001, S_ROW = 11'h002, S_RASF = 11'h004, S_COL = 11'h008,
    S_CASF = 11'h010, S_RD = 11'h020, S_DRV = 11'h040, S_WE = 11'h080,
    S_END = 11'h100, S_PAGE = 11'h200, S_PRE = 11'h400
  } vrc_state_t;
  vrc_state_t state_reg;
  vrc_op_t op_reg;
  vrc_tim_t tim_reg;
  logic masked_reg, page_reg, pending_reg;
  logic [1:0] be_reg;
  logic [8:0] row_reg, open_row_reg;
  logic [7:0] col_reg;
  logic [15:0] wdata_reg, mask_reg, rdata_reg;
  logic [10:0] ras_cnt_reg;
  logic [7:0] a_addr_reg;
  logic a_wr_reg;
  // --------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------------------------
  logic busy, accept_ctrl;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = pending_reg || !(state_reg == S_IDLE || state_reg == S_PAGE);
  assign accept_ctrl = a_wr_reg && a_addr_reg == VRC_CTRL_OFS && !busy;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr_reg <= 8'h00;
      a_wr_reg <= 1'b0;
    end else if (hready) begin
      a_addr_reg <= haddr[7:0];
      a_wr_reg <= hsel && htrans[1] && hwrite;
    end
  end
  // Read data is latched in the address phase so it is ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == VRC_RDATA_OFS) begin
        hrdata <= {16'h0000, rdata_reg};
      end else if (haddr[7:0] == VRC_STATUS_OFS) begin
        hrdata <= {29'h0000_0000, state_reg == S_PAGE, !row_strobe_n, busy};
      end else if (haddr[7:0] == VRC_ADDR_OFS) begin
        hrdata <= {8'h00, col_reg, 7'h00, row_reg};
      end else if (haddr[7:0] == VRC_WDATA_OFS) begin
        hrdata <= {16'h0000, wdata_reg};
      end else if (haddr[7:0] == VRC_MASK_OFS) begin
        hrdata <= {16'h0000, mask_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_reg <= 9'h000;
      col_reg <= 8'h00;
      wdata_reg <= VRC_DATA_RESET;
      mask_reg <= VRC_DATA_RESET;
    end else if (a_wr_reg && !busy) begin
      if (a_addr_reg == VRC_ADDR_OFS) begin
        row_reg <= hwdata[8:0];
        col_reg <= hwdata[VRC_ADDR_COL_LSB +: 8];
      end else if (a_addr_reg == VRC_WDATA_OFS) begin
        wdata_reg <= hwdata[15:0];
      end else if (a_addr_reg == VRC_MASK_OFS) begin
        mask_reg <= hwdata[15:0];
      end
    end
  end
  // Control write while busy is dropped; software polls the busy bit first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_reg <= VRC_OP_READ;
      tim_reg <= VRC_TIM_EARLY;
      masked_reg <= 1'b0;
      be_reg <= 2'b00;
      page_reg <= 1'b0;
    end else if (accept_ctrl) begin
      op_reg <= vrc_op_t'(hwdata[VRC_CTRL_OP_LSB +: 3]);
      tim_reg <= vrc_tim_t'(hwdata[VRC_CTRL_TIM_LSB +: 2]);
      masked_reg <= hwdata[VRC_CTRL_MASKED_BIT];
      be_reg <= hwdata[VRC_CTRL_BE_LSB +: 2];
      page_reg <= hwdata[VRC_CTRL_PAGE_BIT];
    end
  end
  // --------------------------------------------------------------------
  // Per-operation decode
  // --------------------------------------------------------------------
  logic is_reg_op, is_colour, is_write, is_read, page_ok, early, use_oe, col_flag;
  logic [1:0] col_we_n;
  assign is_reg_op = op_reg[2];
  assign is_colour = op_reg == VRC_OP_LOAD_COLOUR || op_reg == VRC_OP_READ_COLOUR;
  assign is_read = op_reg == VRC_OP_READ || op_reg == VRC_OP_READ_MASK
                   || op_reg == VRC_OP_READ_COLOUR;
  assign is_write = !is_read && op_reg != VRC_OP_FLASH;
  assign page_ok = op_reg == VRC_OP_READ || op_reg == VRC_OP_WRITE
                   || op_reg == VRC_OP_BLOCK; // R12
  // Register loads have no read-modify-write form; treat it as delayed
  assign early = is_write && tim_reg == VRC_TIM_EARLY; // R5
  assign use_oe = is_read || (is_write && tim_reg == VRC_TIM_RMW && !is_reg_op);
  assign col_flag = op_reg == VRC_OP_BLOCK || is_colour; // R18 R23
  assign col_we_n = early ? ~be_reg : 2'b11; // R6
  // --------------------------------------------------------------------
  // Row strobe low time, for closing an open page in time
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ras_cnt_reg <= 11'h000;
    end else if (row_strobe_n) begin
      ras_cnt_reg <= 11'h000;
    end else begin
      ras_cnt_reg <= ras_cnt_reg + 11'h001;
    end
  end
  logic page_expired;
  assign page_expired = ras_cnt_reg >= 11'(VRC_PAGE_LIMIT_CYC - PAGE_MARGIN); // R13
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_reg <= 1'b0;
    end else if (accept_ctrl) begin
      pending_reg <= 1'b1;
    end else if (pending_reg && (state_reg == S_IDLE || (state_reg == S_PAGE && page_ok
                 && row_reg == open_row_reg && !page_expired))) begin
      pending_reg <= 1'b0;
    end
  end
  // --------------------------------------------------------------------
  // Strobe sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      upper_byte_write_strobe_n <= 1'b1;
      lower_byte_write_strobe_n <= 1'b1;
      transfer_output_enable_n <= 1'b1;
      special_function_flag <= 1'b0;
      dram_addr <= 9'h000;
      dram_data_out <= VRC_DATA_RESET;
      dram_data_oe_n <= 1'b1;
      rdata_reg <= VRC_DATA_RESET;
      open_row_reg <= 9'h000;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (pending_reg) begin
            dram_addr <= row_reg; // R2
            open_row_reg <= row_reg;
            column_strobe_n <= 1'b1; // R1
            transfer_output_enable_n <= 1'b1; // R1
            special_function_flag <= op_reg == VRC_OP_FLASH || is_reg_op; // R14 R16 R17
            // One strobe low at row fall asks for a mask; flash needs it always
            lower_byte_write_strobe_n <= !(masked_reg && !is_reg_op)
                                         && op_reg != VRC_OP_FLASH; // R9 R17 R22
            upper_byte_write_strobe_n <= 1'b1; // R4 R21
            dram_data_out <= mask_reg; // R9 R10
            // Flash always takes its I/O mask from the pins, masked bit or not
            dram_data_oe_n <= !(masked_reg && !is_reg_op) && op_reg != VRC_OP_FLASH; // R17
            state_reg <= S_ROW;
          end
        end
        S_ROW: begin
          row_strobe_n <= 1'b0;
          state_reg <= S_RASF;
        end
        S_RASF, S_PAGE: begin
          if (state_reg == S_RASF && op_reg == VRC_OP_FLASH) begin
            state_reg <= S_END; // R17
          end else if (state_reg == S_PAGE && (page_expired || (pending_reg
                       && (!page_ok || row_reg != open_row_reg)))) begin
            row_strobe_n <= 1'b1; // R13
            state_reg <= S_PRE;
          end else if (state_reg == S_RASF || pending_reg) begin
            dram_addr <= {1'b0, col_reg}; // R2 R12
            special_function_flag <= col_flag; // R18 R23
            upper_byte_write_strobe_n <= col_we_n[1]; // R5
            lower_byte_write_strobe_n <= col_we_n[0]; // R5
            dram_data_out <= wdata_reg; // R19
            dram_data_oe_n <= !early; // R5
            state_reg <= S_COL;
          end
        end
        S_COL: begin
          column_strobe_n <= 1'b0;
          state_reg <= S_CASF;
        end
        S_CASF: begin
          if (use_oe) begin
            transfer_output_enable_n <= 1'b0; // R3
            state_reg <= S_RD;
          end else if (early) begin
            state_reg <= S_END;
          end else begin
            dram_data_oe_n <= 1'b0; // R7
            state_reg <= S_WE;
          end
        end
        S_RD: begin
          rdata_reg <= dram_data_in; // R3
          transfer_output_enable_n <= 1'b1; // R8
          state_reg <= is_write ? S_DRV : S_END;
        end
        S_DRV: begin
          dram_data_oe_n <= 1'b0; // R8
          state_reg <= S_WE;
        end
        S_WE: begin
          upper_byte_write_strobe_n <= !be_reg[1]; // R6 R7 R20
          lower_byte_write_strobe_n <= !be_reg[0]; // R6 R7 R20
          state_reg <= S_END;
        end
        S_END: begin
          column_strobe_n <= 1'b1;
          upper_byte_write_strobe_n <= 1'b1;
          lower_byte_write_strobe_n <= 1'b1;
          transfer_output_enable_n <= 1'b1;
          special_function_flag <= 1'b0;
          dram_data_oe_n <= 1'b1;
          if (page_reg && page_ok) begin
            state_reg <= S_PAGE; // R10 R12
          end else begin
            row_strobe_n <= 1'b1;
            state_reg <= S_PRE;
          end
        end
        default: begin
          // Precharge, and any stray code, go back to idle
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Checks on the pin sequence
  // --------------------------------------------------------------------
  a_random_select: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    $fell(row_strobe_n) |-> transfer_output_enable_n && column_strobe_n && $past(dram_addr)
      == open_row_reg)
    else $error("random cycle not selected at row strobe fall");

  a_delayed_oe_high: assert property ( // R7
    @(posedge hclk) disable iff (!hresetn)
    (($fell(upper_byte_write_strobe_n) || $fell(lower_byte_write_strobe_n)) && !column_strobe_n)
      |-> transfer_output_enable_n && !dram_data_oe_n && $past(!column_strobe_n, 2))
    else $error("delayed write strobe without data and high output enable");

  a_rmw_no_clash: assert property ( // R8
    @(posedge hclk) disable iff (!hresetn)
    $rose(transfer_output_enable_n) && !column_strobe_n && is_write
      |-> dram_data_oe_n ##1 !dram_data_oe_n ##1 $fell(lower_byte_write_strobe_n)
      || $fell(upper_byte_write_strobe_n))
    else $error("write data driven before output enable rose");

  a_page_limit: assert property ( // R13
    @(posedge hclk) disable iff (!hresetn)
    ras_cnt_reg < 11'(VRC_PAGE_LIMIT_CYC))
    else $error("row strobe low too long");

  a_reg_select: assert property ( // R23
    @(posedge hclk) disable iff (!hresetn)
    $fell(column_strobe_n) && is_reg_op |-> special_function_flag == is_colour
      && $past(special_function_flag, 3))
    else $error("wrong flag level for register cycle");
endmodule

// File: hdl/vrc_pkg.sv
// Constants for the video DRAM random-port controller.
// Assumes a 10 MHz hclk and one AHB-Lite slave port in front of the controller.
// How it works
// R1 - Transfer/output-enable and column strobe high at row strobe fall select random cycles.
// R2 - Device takes row address at row strobe fall, column at column strobe fall.
// R3 - Read: column strobe low, write strobes high, output enable low gives data.
// R4 - Both write strobes high at row fall means unmasked; write on strobes low later.
// R5 - Write strobe before column strobe is early write; all 16 bits latched there.
// R6 - Early write with one strobe low writes one byte; later strobe reuses data.
// R7 - Write strobe after column strobe is delayed write; keep output enable high.
// R8 - Read-modify-write: read first, then raise output enable, then drive write data.
// R9 - Write strobe low at row fall: data pins give a per-bit write mask.
// R10 - A new mask lasts the whole row-low period, page accesses included.
// R11 - After load-mask, the stored mask is used until a mask-reset refresh.
// R12 - Row held low, each column strobe toggle reaches another word of the row.
// R13 - Row strobe low period in page mode must stay within 100 us.
// R14 - Colour register cycle: all of column, transfer, write strobes and flag high.
// R15 - Colour register cycle refreshes the row; read, early and delayed timing.
// R16 - Mask register cycle shares the colour register row decode, 16-bit register.
// R17 - Flash write: flag high and a write strobe low at row fall fills the row.
// R18 - Block write: flag low at row fall, high with write strobe low at column.
// R19 - Block write column mask comes from data pins 0 to 3 only.
// R20 - Block write allows early, delayed, read-modify-write and page timing.
// R21 - Unmasked block write fills all 16 bit positions.
// R22 - Masked block write keeps bits whose mask is low.
// R23 - Flag at column strobe fall: low picks mask register, high colour register.
// R24 - Persistent mask stays until a refresh with register reset.
package vrc_pkg;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0] VRC_CTRL_OFS = 8'h00;
  localparam logic [7:0] VRC_ADDR_OFS = 8'h04;
  localparam logic [7:0] VRC_WDATA_OFS = 8'h08;
  localparam logic [7:0] VRC_MASK_OFS = 8'h0C;
  localparam logic [7:0] VRC_RDATA_OFS = 8'h10;
  localparam logic [7:0] VRC_STATUS_OFS = 8'h14;
  // Control fields
  localparam int VRC_CTRL_OP_LSB = 0;
  localparam int VRC_CTRL_TIM_LSB = 3;
  localparam int VRC_CTRL_MASKED_BIT = 5;
  localparam int VRC_CTRL_BE_LSB = 6;
  localparam int VRC_CTRL_PAGE_BIT = 8;
  localparam int VRC_ADDR_COL_LSB = 16;
  localparam logic [15:0] VRC_DATA_RESET = 16'h0000;
  // --------------------------------------------------------------------
  // Operations and write timing
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    VRC_OP_READ = 3'h0, VRC_OP_WRITE = 3'h1, VRC_OP_BLOCK = 3'h2, VRC_OP_FLASH = 3'h3,
    VRC_OP_LOAD_MASK = 3'h4, VRC_OP_LOAD_COLOUR = 3'h5, VRC_OP_READ_MASK = 3'h6,
    VRC_OP_READ_COLOUR = 3'h7
  } vrc_op_t;
  typedef enum logic [1:0] {
    VRC_TIM_EARLY = 2'h0, VRC_TIM_DELAYED = 2'h1, VRC_TIM_RMW = 2'h2
  } vrc_tim_t;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int VRC_CLK_NS = 100;
  localparam int VRC_PAGE_LIMIT_US = 100;
  localparam int VRC_PAGE_LIMIT_CYC = (VRC_PAGE_LIMIT_US * 1000) / VRC_CLK_NS;
endpackage

// File: sim/vrc_ctrl_test.sv
// Self-checking bench: AHB-Lite master in front of the controller, DRAM model behind.
// Assumes the controller's register map and zero-wait slave.
`timescale 1ns/1ps
module vrc_ctrl_test;
  import vrc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ras_n, cas_n, ub_we_n, lb_we_n, toe_n;
  logic flag, doe_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [8:0] dram_addr;
  logic [15:0] dout, din;
  int num_errors, check_count, cyc, f0;
  vrc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .row_strobe_n(ras_n),
    .column_strobe_n(cas_n), .upper_byte_write_strobe_n(ub_we_n),
    .lower_byte_write_strobe_n(lb_we_n), .transfer_output_enable_n(toe_n),
    .special_function_flag(flag), .dram_addr(dram_addr), .dram_data_out(dout),
    .dram_data_oe_n(doe_n), .dram_data_in(din));
  vrc_dram_model u_dev (.row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .upper_byte_write_strobe_n(ub_we_n), .lower_byte_write_strobe_n(lb_we_n),
    .transfer_output_enable_n(toe_n), .special_function_flag(flag), .dram_addr(dram_addr),
    .dram_data_out(dout), .dram_data_oe_n(doe_n), .dram_data_in(din));
  always #50 hclk = ~hclk;
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Polls busy; a hang is left to the cycle ceiling
  task automatic wait_idle;
    do ahb(1'b0, VRC_STATUS_OFS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] tm, input logic mk,
      input logic [1:0] be, input logic pg, input logic [8:0] r, input logic [7:0] c,
      input logic [15:0] d, input logic [15:0] m);
    wait_idle;
    ahb(1'b1, VRC_ADDR_OFS, {8'h00, c, 7'h00, r});
    ahb(1'b1, VRC_WDATA_OFS, {16'h0000, d});
    ahb(1'b1, VRC_MASK_OFS, {16'h0000, m});
    ahb(1'b1, VRC_CTRL_OFS, {23'h000000, pg, be, mk, tm, op});
    wait_idle;
  endtask
  task automatic rdw(input logic [8:0] r, input logic [7:0] c, input logic [15:0] e);
    cmd(VRC_OP_READ, VRC_TIM_EARLY, 1'b0, 2'h3, 1'b0, r, c, 16'h0000, 16'h0000);
    ahb(1'b0, VRC_RDATA_OFS, 32'h0);
    check(rd, {16'h0000, e});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      give_verdict;
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {hclk, hresetn, haddr, htrans, hwrite, hwdata, num_errors, check_count, cyc} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    check({26'h0, ras_n, cas_n, ub_we_n, lb_we_n, toe_n, flag}, 32'h0000003E);
    hresetn <= 1'b1;
    cmd(VRC_OP_LOAD_COLOUR, VRC_TIM_EARLY, 0, 3, 0, 3, 0, 16'hA5C3, 0);
    cmd(VRC_OP_READ_COLOUR, VRC_TIM_EARLY, 0, 3, 0, 3, 0, 0, 0);
    ahb(1'b0, VRC_RDATA_OFS, 32'h0);
    check(rd, 32'h0000A5C3);
    cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 0, 3, 0, 5, 10, 16'h1234, 0);
    rdw(5, 10, 16'h1234);
    cmd(VRC_OP_WRITE, VRC_TIM_DELAYED, 0, 1, 0, 5, 10, 16'hFFFF, 0);
    rdw(5, 10, 16'h12FF);
    cmd(VRC_OP_WRITE, VRC_TIM_RMW, 0, 2, 0, 5, 10, 16'hABCD, 0);
    rdw(5, 10, 16'hABFF);
    cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 0, 1, 0, 5, 11, 16'h5A5A, 0);
    rdw(5, 11, 16'h005A);
    cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 1, 3, 0, 5, 10, 16'h0000, 16'h00F0);
    rdw(5, 10, 16'hAB0F);
    f0 = u_dev.falls;
    for (int c = 0; c < 4; c++) cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 0, 3, 1, 6, c[7:0],
      16'h1110 + c[15:0], 0);
    check(rd, 32'h00000006);
    rdw(6, 3, 16'h1113);
    check(32'(u_dev.falls - f0), 32'h00000001);
    rdw(6, 0, 16'h1110);
    cmd(VRC_OP_BLOCK, VRC_TIM_EARLY, 0, 3, 0, 8, 8'h41, 16'h0005, 0);
    for (int i = 0; i < 4; i++) rdw(8, 8'h40 + i[7:0], i[0] ? 16'h0000 : 16'hA5C3);
    cmd(VRC_OP_BLOCK, VRC_TIM_DELAYED, 1, 2, 0, 8, 8'h48, 16'h000F, 16'hFF00);
    rdw(8, 8'h4A, 16'hA500);
    cmd(VRC_OP_FLASH, VRC_TIM_EARLY, 0, 3, 0, 7, 0, 0, 16'h0F0F);
    rdw(7, 0, 16'h0503);
    rdw(7, 255, 16'h0503);
    cmd(VRC_OP_LOAD_MASK, VRC_TIM_DELAYED, 0, 3, 0, 3, 0, 16'h00FF, 0);
    cmd(VRC_OP_READ_MASK, VRC_TIM_EARLY, 0, 3, 0, 3, 0, 0, 0);
    ahb(1'b0, VRC_RDATA_OFS, 32'h0);
    check(rd, 32'h000000FF);
    cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 1, 3, 0, 5, 10, 16'hFFFF, 16'hFFFF);
    rdw(5, 10, 16'hABFF);
    cmd(VRC_OP_WRITE, VRC_TIM_EARLY, 0, 3, 1, 9, 0, 16'h0001, 0);
    repeat (1100) @(posedge hclk);
    ahb(1'b0, VRC_STATUS_OFS, 32'h0);
    check(rd, 32'h00000000);
    check({31'h0, u_dev.max_low <= 100000.0}, 32'h00000001);
    check(32'(u_dev.faults), 32'h00000000);
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h00000000);
    check({30'h0, hresp, hreadyout}, 32'h00000001);
    give_verdict;
  end
endmodule

// File: sim/vrc_dram_model.sv
// Behavioural random port of the video DRAM, edge-driven like the real part.
// Assumes the controller's data drive and enable; resolves the data pins here.
`timescale 1ns/1ps
module vrc_dram_model (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic upper_byte_write_strobe_n,
  input wire logic lower_byte_write_strobe_n,
  input wire logic transfer_output_enable_n,
  input wire logic special_function_flag,
  input wire logic [8:0] dram_addr,
  input wire logic [15:0] dram_data_out,
  input wire logic dram_data_oe_n,
  output logic [15:0] dram_data_in
);
  logic [15:0] mem [512][256];
  logic [15:0] colour, pmask, mask, lat, q, last, pin;
  logic [8:0] row;
  logic [7:0] col;
  logic rnd, dsf, wm, cf, early, pers, drv;
  int falls, faults;
  realtime t0, max_low;
  // ------------------------------------------------------------
  // Pin resolution
  // ------------------------------------------------------------
  // Nobody driving: show the inverse of the last level, no pull on these pins
  assign drv = !row_strobe_n && !column_strobe_n && !transfer_output_enable_n &&
    upper_byte_write_strobe_n && lower_byte_write_strobe_n;
  assign q = dsf ? (cf ? colour : pmask) : mem[row][col];
  assign pin = !dram_data_oe_n ? dram_data_out : drv ? q : ~last;
  assign dram_data_in = pin;
  always @(pin) if (!dram_data_oe_n || drv) last = pin;
  initial begin
    for (int r = 0; r < 512; r++) for (int c = 0; c < 256; c++) mem[r][c] = 16'h0000;
    {colour, pmask, last, pers, falls, faults} = '0;
    t0 = 0.0;
    max_low = 0.0;
  end
  // ------------------------------------------------------------
  // Cycle decode and writes
  // ------------------------------------------------------------
  function automatic logic [15:0] put(input logic [15:0] old, d, input logic [1:0] be);
    logic [15:0] m;
    m = mask & {{8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (d & m);
  endfunction
  task automatic wr(input logic [1:0] be);
    if (dsf && !wm && !cf) {pmask, pers} = {lat, 1'b1};
    else if (dsf && !wm) colour = lat;
    else if (cf) begin
      for (int i = 0; i < 4; i++)
        if (lat[i]) mem[row][{col[7:2], i[1:0]}] = put(mem[row][{col[7:2], i[1:0]}],
          colour, be);
    end else if (!dsf) mem[row][col] = put(mem[row][col], lat, be);
  endtask
  always @(negedge row_strobe_n) begin
    row = dram_addr;
    rnd = transfer_output_enable_n && column_strobe_n;
    if (!rnd) faults++;
    dsf = special_function_flag;
    wm = !(upper_byte_write_strobe_n && lower_byte_write_strobe_n);
    mask = !wm ? 16'hFFFF : pers ? pmask : pin;
    falls++;
    t0 = $realtime;
    if (rnd && dsf && wm) for (int c = 0; c < 256; c++) mem[row][c] = put(mem[row][c],
      colour, 2'h3);
  end
  always @(posedge row_strobe_n) if ($realtime - t0 > max_low) max_low = $realtime - t0;
  always @(negedge column_strobe_n) if (!row_strobe_n) begin
    col = dram_addr[7:0];
    cf = special_function_flag;
    early = !(upper_byte_write_strobe_n && lower_byte_write_strobe_n);
    lat = pin;
    if (early) wr(~{upper_byte_write_strobe_n, lower_byte_write_strobe_n});
  end
  always @(negedge upper_byte_write_strobe_n) if (!column_strobe_n && !row_strobe_n) begin
    if (!early) lat = pin;
    wr(2'b10);
  end
  always @(negedge lower_byte_write_strobe_n) if (!column_strobe_n && !row_strobe_n) begin
    if (!early) lat = pin;
    wr(2'b01);
  end
endmodule
